/* File: hw/i2c_slave_cond_ack.sv */
/*
 Two-wire slave: Start/Stop/Restart detection, data hold select,
 collision flagging, acknowledge generation, address matching with
 mask and 10-bit prior match, received bytes buffered in a FIFO.
 Assumes pins arrive asynchronously and an outer wire resolves the
 open-drain data line from o_sda_oe_n.
*/
`timescale 1ns/1ns

// ========================================
// Receive FIFO
module rx_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input  wire logic             i_clock,
    input  wire logic             i_sys_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH)
        $error("rx_fifo: DEPTH must be a power of two, at least 2");

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign o_in_ready  = count_r != (AW+1)'(DEPTH);
    assign o_out_valid = count_r != '0;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem[rd_ptr_r];

    // Storage, no reset needed on the data words
    always_ff @(posedge i_clock)
    begin
        if (push)
            mem[wr_ptr_r] <= i_in_data;
    end

    // Pointers and count
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ========================================
// Slave core
// Behaviour
// R1: Hold select stretches data hold to 300 ns
// R2: Line low while expecting high flags collision
// R3: SDA falls with SCL high is Start
// R4: SDA low before own drive flags Start collision
// R5: SDA rises with SCL high is Stop
// R6: Stop needs a prior SCL low period
// R7: Restart resets protocol state like Start
// R8: 10-bit read needs full address then Restart
// R9: Prior-match kept until Stop or failed/write high
// R10: Start/Stop irq enables add irqs elsewhere
// R11: Ninth pulse is acknowledge; receiver pulls low
// R12: Received ninth-bit level stored in status bit
// R13: Hold modes drive software acknowledge value
// R14: No hold modes: hardware acknowledges itself
// R15: Full buffer or overflow withholds acknowledge
// R16: Ack-time status set after eighth fall
// R17: Mode field picks four 7/10-bit modes
// R18: Start/Stop modes flag every condition
// R19: First byte after Start compared to address
// R20: Match loads byte and raises interrupt flag
// R21: Mismatch returns idle silently; with a full buffer the overflow flag is still set
// R22: Mask bits exclude positions from match; mask bits 9:8 are unused, so the 10-bit high byte is never masked
// R23: 7-bit match ignores direction bit
// R24: 10-bit high byte is 11110 A9 A8 0
// R25: Bytes shift most significant bit first
// R26: Clock and data synchronised before use
module i2c_slave_cond_ack
    import i2c_slave_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    input  wire logic [1:0] i_port_mode_select,
    input  wire logic       i_hold_time_select,
    input  wire logic       i_start_irq_enable,
    input  wire logic       i_stop_irq_enable,
    input  wire logic       i_address_hold_enable,
    input  wire logic       i_data_hold_enable,
    input  wire logic       i_ack_data_bit,
    input  wire logic [9:0] i_slave_address,
    input  wire logic [9:0] i_address_mask,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_irq_clear,
    input  wire logic       i_overflow_clear,
    input  wire logic       i_collision_clear,
    output logic            o_rx_valid,
    input  wire logic       i_rx_ready,
    output logic [7:0]      o_rx_data,
    output logic            o_buffer_full_flag,
    output logic            o_receive_overflow_flag,
    output logic            o_port_interrupt_flag,
    output logic            o_ack_status_bit,
    output logic            o_ack_time_status,
    output logic            o_bus_collision,
    output logic            o_prior_match,
    output logic            o_start_seen,
    output logic            o_stop_seen
);
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_ADDR_LO = 3'b010,
        ST_RX      = 3'b011,
        ST_TX      = 3'b100
    } slave_state_e;

    // Masked equality; set mask bits drop out of the compare
    function automatic logic addr_eq(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input logic [7:0] m);
        addr_eq = ((a ^ b) & ~m) == 8'h00;
    endfunction

    slave_state_e state_r;
    logic         scl_s1, scl_s2, scl_d;
    logic         sda_s1, sda_s2, sda_d;
    logic         scl_rise, scl_fall, start_det, stop_det;
    logic         scl_low_seen_r;
    logic [3:0]   bit_cnt_r;
    logic [7:0]   rx_sh_r;
    logic [7:0]   tx_sh_r;
    logic [4:0]   hold_cnt_r;
    logic         sda_low_r;
    logic         want_low;
    logic         ack_go_r;
    logic         hold_mode;
    logic         eighth_fall, ninth_fall;
    logic         ten_bit, sp_mode;
    logic         hi_ok, match7, match_lo;
    logic         fifo_ready, push;
    logic         coll_r, ovf_r, irq_r, ack_status_bit_r, ack_time_status_r;
    logic         prior_r, start_r, stop_r;
    logic         irq_set, coll_set;

    // Two sync flops plus a delay flop on each pin; the second and delay flops feed logic
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            {scl_s1, scl_s2, scl_d} <= 3'h7;
            {sda_s1, sda_s2, sda_d} <= 3'h7;
        end
        else
        begin
            scl_s1 <= i_scl;                                   // R26
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= i_sda;                                   // R26
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    // Edge and condition decode on the synchronised lines
    assign scl_rise  = scl_s2 && !scl_d;
    assign scl_fall  = !scl_s2 && scl_d;
    assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;   // R3
    assign stop_det  = scl_s2 && scl_d && !sda_d && sda_s2 &&
                       scl_low_seen_r;                        // R5 R6
    assign ten_bit   = i_port_mode_select[MODE_10_POS];        // R17
    assign sp_mode   = i_port_mode_select[MODE_SP_POS];        // R17
    assign eighth_fall = scl_fall && bit_cnt_r == BIT_EIGHTH;
    assign ninth_fall  = scl_fall && bit_cnt_r == BIT_NINTH;
    assign hold_mode = (state_r == ST_RX) ? i_data_hold_enable
                                          : i_address_hold_enable;

    // Address compares: 7-bit skips R/W, 10-bit high has fixed prefix
    assign match7   = addr_eq({rx_sh_r[7:1], 1'b0},
                              {i_slave_address[6:0], 1'b0},
                              {i_address_mask[6:0], 1'b1});   // R22 R23
    assign hi_ok    = rx_sh_r[7:1] ==
                      {ADDR10_PREFIX, i_slave_address[9:8]};  // R24
    assign match_lo = addr_eq(rx_sh_r, i_slave_address[7:0],
                              i_address_mask[7:0]);           // R22

    // A byte is accepted only with room and no overflow pending
    assign push = eighth_fall && fifo_ready && !ovf_r &&
                  ((state_r == ST_ADDR && !ten_bit && match7) ||
                   (state_r == ST_ADDR && ten_bit && hi_ok &&
                    (!rx_sh_r[0] || prior_r)) ||
                   (state_r == ST_ADDR_LO && match_lo) ||
                   state_r == ST_RX);                         // R15 R20

    // Line value wanted now; applied only once hold has expired
    always_comb
    begin
        want_low = 1'b0;
        if (state_r == ST_TX && bit_cnt_r < BIT_EIGHTH)
            want_low = !tx_sh_r[7];                           // R25
        else if (state_r != ST_IDLE && state_r != ST_TX &&
                 bit_cnt_r >= BIT_EIGHTH)
            want_low = ack_go_r &&
                       (hold_mode ? !i_ack_data_bit : 1'b1);  // R11 R13 R14
    end

    // Hold counter restarts on every SCL fall
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            hold_cnt_r <= '0;
        else if (scl_fall)
            hold_cnt_r <= i_hold_time_select ?
                          5'(HOLD_LONG_CYC - 1) :
                          5'(HOLD_SHORT_CYC - 1);             // R1
        else if (hold_cnt_r != '0)
            hold_cnt_r <= hold_cnt_r - 1'b1;
    end

    // Drive register; releases at once on any bus condition
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || start_det || stop_det)
            sda_low_r <= 1'b0;
        else if (hold_cnt_r == '0 && !scl_fall)
            sda_low_r <= want_low;                            // R1
    end

    // SCL low seen since the last bus condition
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || start_det || stop_det)
            scl_low_seen_r <= 1'b0;
        else if (!scl_s2)
            scl_low_seen_r <= 1'b1;                           // R6
    end

    // Protocol state, bit count and shifters
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || stop_det)
        begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= '0;
            rx_sh_r   <= SHIFT_RST;
            tx_sh_r   <= SHIFT_RST;
            ack_go_r  <= 1'b0;
        end
        else if (start_det)
        begin
            state_r   <= ST_ADDR;                             // R7 R19
            bit_cnt_r <= '0;
            ack_go_r  <= 1'b0;
        end
        else if (coll_set)
            state_r <= ST_IDLE;
        else if (state_r != ST_IDLE)
        begin
            if (scl_rise && bit_cnt_r < BIT_EIGHTH)
            begin
                rx_sh_r   <= {rx_sh_r[6:0], sda_s2};          // R25
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
            else if (scl_rise && bit_cnt_r == BIT_EIGHTH)
                bit_cnt_r <= BIT_NINTH;
            if (scl_fall && state_r == ST_TX && bit_cnt_r != '0 &&
                bit_cnt_r < BIT_EIGHTH)
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};              // R25
            if (eighth_fall)
                ack_go_r <= push;                             // R15
            if (ninth_fall)
            begin
                bit_cnt_r <= '0;
                tx_sh_r   <= i_tx_data;
                unique case (state_r)
                    ST_ADDR:
                        if (!sda_low_r)
                            state_r <= ST_IDLE;               // R21
                        else if (!ten_bit)
                            state_r <= rx_sh_r[0] ? ST_TX : ST_RX;
                        else if (rx_sh_r[0])
                            state_r <= ST_TX;                 // R8
                        else
                            state_r <= ST_ADDR_LO;
                    ST_ADDR_LO, ST_RX:
                        state_r <= sda_low_r ? ST_RX : ST_IDLE;
                    ST_TX:
                        if (ack_status_bit_r)
                            state_r <= ST_IDLE;
                    ST_IDLE:
                        state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // 10-bit prior match flag
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || stop_det)
            prior_r <= 1'b0;                                  // R9
        else if (eighth_fall && ten_bit)
        begin
            if (state_r == ST_ADDR_LO && match_lo)
                prior_r <= 1'b1;                              // R9
            else if (state_r == ST_ADDR_LO ||
                     (state_r == ST_ADDR &&
                      (!hi_ok || !rx_sh_r[0])))
                prior_r <= 1'b0;                              // R9
        end
    end

    // Acknowledge level from the master on the ninth rise
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            ack_status_bit_r <= 1'b0;
        else if (scl_rise && bit_cnt_r == BIT_EIGHTH &&
                 state_r == ST_TX)
            ack_status_bit_r <= sda_s2;                              // R12
    end

    // Ack-time status: eighth fall to ninth fall, hold modes only
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst || start_det || stop_det || ninth_fall)
            ack_time_status_r <= 1'b0;
        else if (eighth_fall && push && state_r != ST_TX &&
                 (i_address_hold_enable || i_data_hold_enable))
            ack_time_status_r <= 1'b1;                                 // R16
    end

    // Collision: line low while this end leaves it high
    assign coll_set = (state_r == ST_TX && scl_rise &&
                       bit_cnt_r < BIT_EIGHTH && !sda_low_r &&
                       !sda_s2) ||                            // R2
                      (start_det && state_r == ST_TX &&
                       bit_cnt_r < BIT_EIGHTH && !sda_low_r); // R4

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            coll_r <= 1'b0;
            ovf_r  <= 1'b0;
        end
        else
        begin
            coll_r <= coll_set || (coll_r && !i_collision_clear);
            ovf_r  <= (eighth_fall && !fifo_ready &&
                       state_r != ST_IDLE && state_r != ST_TX) ||
                      (ovf_r && !i_overflow_clear);
        end
    end

    // Interrupt sources
    assign irq_set = push ||                                  // R20
                     (ninth_fall && state_r == ST_TX &&
                      !ack_status_bit_r) ||
                     (start_det &&
                      (sp_mode || i_start_irq_enable)) ||     // R10 R18
                     (stop_det &&
                      (sp_mode || i_stop_irq_enable));        // R10 R18

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            irq_r <= 1'b0;
        else
            irq_r <= irq_set || (irq_r && !i_irq_clear);
    end

    // Last bus condition seen
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            start_r <= 1'b0;
            stop_r  <= 1'b0;
        end
        else if (start_det || stop_det)
        begin
            start_r <= start_det;
            stop_r  <= stop_det;
        end
    end

    rx_fifo #(.WIDTH(RX_FIFO_WIDTH), .DEPTH(RX_FIFO_DEPTH)) u_fifo (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_in_valid (push),
        .o_in_ready (fifo_ready),
        .i_in_data  (rx_sh_r),
        .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready),
        .o_out_data (o_rx_data)
    );

    assign o_sda                   = 1'b0;
    assign o_sda_oe_n              = !sda_low_r;
    assign o_buffer_full_flag      = !fifo_ready;
    assign o_receive_overflow_flag = ovf_r;
    assign o_port_interrupt_flag   = irq_r;
    assign o_ack_status_bit        = ack_status_bit_r;
    assign o_ack_time_status       = ack_time_status_r;
    assign o_bus_collision         = coll_r;
    assign o_prior_match           = prior_r;
    assign o_start_seen            = start_r;
    assign o_stop_seen             = stop_r;

    // ========================================
    // Assertions
    a_hold_long_load: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) scl_fall && i_hold_time_select
        |=> hold_cnt_r == 5'(HOLD_LONG_CYC - 1))             // R1
        else $error("long hold not loaded");
    a_hold_no_change: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) scl_fall && i_hold_time_select
        && !start_det ##1 !start_det[*8] |-> $stable(sda_low_r))  // R1
        else $error("data changed inside hold");
    a_tx_collision: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) coll_set |=> coll_r
        && (state_r == ST_IDLE || $past(start_det)))          // R2
        else $error("collision not flagged");
    a_start_reset: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) start_det && !stop_det
        |=> state_r == ST_ADDR && bit_cnt_r == 4'h0)          // R3
        else $error("start did not reset state");
    a_stop_idle: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) stop_det
        |=> state_r == ST_IDLE && !prior_r && stop_r)         // R5
        else $error("stop did not idle");
    a_stop_low_seen: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) stop_det |-> scl_low_seen_r)  // R6
        else $error("stop without scl low");
    a_ack_status: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) scl_rise && state_r == ST_TX
        && bit_cnt_r == BIT_EIGHTH && !start_det && !stop_det
        |=> ack_status_bit_r == $past(sda_s2))                       // R12
        else $error("ack level not stored");
    a_full_nack: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) eighth_fall && !fifo_ready
        |=> !ack_go_r)                                        // R15
        else $error("ack given while full");
    a_mismatch_quiet: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) eighth_fall && state_r == ST_ADDR
        && !ten_bit && !match7 |-> !push)                     // R21
        else $error("mismatch produced data");
    a_sp_irq: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) (start_det || stop_det) && sp_mode
        |=> irq_r)                                            // R18
        else $error("condition irq missing");
    a_ack_time_set: assert property (@(posedge i_clock)
        disable iff (i_sys_rst) eighth_fall && push && !start_det
        && !stop_det && (i_address_hold_enable || i_data_hold_enable)
        |=> ack_time_status_r)                                         // R16
        else $error("ack time status not set");
    c_start: cover property (@(posedge i_clock) start_det);
    c_match: cover property (@(posedge i_clock) push
        && state_r == ST_ADDR);
    c_stop: cover property (@(posedge i_clock) stop_det);
    c_collide: cover property (@(posedge i_clock) coll_set);
endmodule

/* File: hw/i2c_slave_pkg.sv */
/*
 Constants shared by the two-wire slave: modes, address prefix, bit
 counts, hold timing and reset values.
 Assumes a 50 MHz system clock.
*/
package i2c_slave_pkg;
    // ========================================
    // Mode select encoding
    localparam logic [1:0] MODE_7BIT      = 2'b00;
    localparam logic [1:0] MODE_10BIT     = 2'b01;
    localparam logic [1:0] MODE_7BIT_SP   = 2'b10;
    localparam logic [1:0] MODE_10BIT_SP  = 2'b11;
    localparam int         MODE_SP_POS    = 1;  // Start/Stop irq modes
    localparam int         MODE_10_POS    = 0;  // 10-bit modes
    // ========================================
    // Byte framing
    localparam logic [4:0] ADDR10_PREFIX  = 5'h1e;
    localparam logic [3:0] BIT_EIGHTH     = 4'h8;
    localparam logic [3:0] BIT_NINTH      = 4'h9;
    // ========================================
    // Data hold timing
    localparam int         CLK_NS         = 20;
    localparam int         HOLD_LONG_NS   = 300;
    localparam int         HOLD_SHORT_NS  = 100;
    localparam int         HOLD_LONG_CYC  = (HOLD_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int         HOLD_SHORT_CYC = (HOLD_SHORT_NS + CLK_NS - 1) / CLK_NS;
    // ========================================
    // Reset values and buffering
    localparam logic [7:0] SHIFT_RST      = 8'h00;
    localparam int         RX_FIFO_DEPTH  = 16;
    localparam int         RX_FIFO_WIDTH  = 8;
endpackage

/* File: testbench/i2c_master_model.sv */
/*
 Behavioural bus master for the two-wire slave bench.
 Assumes the bench resolves the data line as a pull-up from all enables.
*/
`timescale 1ns/1ns
// ========================================
// Master model
module i2c_master_model
(
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe_n
);
    // Low phase outlasts sync delay plus long hold, so acks land in time
    int t_low = 400;
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // Start or Restart: data falls while clock high
    task start();
        o_sda_oe_n = 1'b1;
        #(t_low / 2);
        o_scl = 1'b1;
        #80;
        o_sda_oe_n = 1'b0;
        #80;
        o_scl = 1'b0;
        #(t_low / 2);
    endtask
    // Low then high on data with clock held high
    task glitch();
        o_sda_oe_n = 1'b0;
        #80;
        o_sda_oe_n = 1'b1;
        #160;
    endtask
    // Data changes only in the low phase, sampled mid high phase
    task bit_x(input logic b, output logic s);
        o_sda_oe_n = b;
        #(t_low / 2);
        o_scl = 1'b1;
        #40;
        s = i_sda;
        #40;
        o_scl = 1'b0;
        #(t_low / 2);
    endtask
    // Byte out or in, then the ack slot
    task xfer(input logic [7:0] d, output logic [7:0] q,
              input logic a, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(a, ack);
    endtask
    // Stop: data rises while clock high
    task stop();
        o_sda_oe_n = 1'b0;
        #(t_low / 2);
        o_scl = 1'b1;
        #80;
        o_sda_oe_n = 1'b1;
        #160;
    endtask
endmodule

/* File: testbench/tb.sv */
/*
 Self-checking bench for the two-wire slave core.
 Assumes the master model drives the clock line and shares the data wire.
*/
`timescale 1ns/1ns
module tb;
    import i2c_slave_pkg::*;
    logic       clk, rst, scl, m_oe_n, s_oe_n, hts, sie, pie, ahe, dhe;
    logic       ackd, irqc, ovc, colc, rdy, rxv, bff, ovf, irq, acks;
    logic       ackt, col, pm, ss, ps, ack;
    logic [1:0] mode;
    logic [9:0] addr, mask;
    logic [7:0] txd, rxd, q;
    int         error_cnt, total_checks;
    wire        sda = m_oe_n & s_oe_n; // Pull-up: any party pulls low
    i2c_master_model M (.i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n));
    i2c_slave_cond_ack DUT (.i_clock(clk), .i_sys_rst(rst), .i_scl(scl),
        .i_sda(sda), .o_sda(), .o_sda_oe_n(s_oe_n),
        .i_port_mode_select(mode), .i_hold_time_select(hts),
        .i_start_irq_enable(sie), .i_stop_irq_enable(pie),
        .i_address_hold_enable(ahe), .i_data_hold_enable(dhe),
        .i_ack_data_bit(ackd), .i_slave_address(addr),
        .i_address_mask(mask), .i_tx_data(txd), .i_irq_clear(irqc),
        .i_overflow_clear(ovc), .i_collision_clear(colc),
        .o_rx_valid(rxv), .i_rx_ready(rdy), .o_rx_data(rxd),
        .o_buffer_full_flag(bff), .o_receive_overflow_flag(ovf),
        .o_port_interrupt_flag(irq), .o_ack_status_bit(acks),
        .o_ack_time_status(ackt), .o_bus_collision(col),
        .o_prior_match(pm), .o_start_seen(ss), .o_stop_seen(ps));
    // ========================================
    // Clock and shared tasks
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task cyc();
        @(posedge clk);
        #1;
    endtask
    task chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Master writes a byte and releases the ack slot
    task wr(input logic [7:0] d, input logic e);
        M.xfer(d, q, 1'b1, ack);
        chk_bit("ack", e, ack);
    endtask
    // Pop happens on the edge where valid and ready meet
    task pop(input logic [7:0] e);
        cyc();
        chk_bit("rx_valid", 1'b1, rxv);
        chk_byte("rx_data", e, rxd);
        rdy = 1'b1;
        cyc();
        rdy = 1'b0;
    endtask
    task automatic pulse(ref logic s);
        cyc();
        s = 1'b1;
        cyc();
        s = 1'b0;
    endtask
    // Hang guard: counts as a mismatch
    initial
    begin
        #2000000;
        error_cnt++;
        complete_run();
    end
    // ========================================
    // Main sequence
    initial
    begin
        {rst, hts, sie, pie, ahe, dhe, ackd, irqc, ovc, colc, rdy} = 11'h400;
        mode = MODE_7BIT;
        addr = 10'h03a;
        mask = 10'h000;
        txd = 8'h96;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) cyc();
        chk_bit("oe_n", 1'b1, s_oe_n);
        chk_bit("irq", 1'b0, irq);
        M.start();
        chk_bit("start", 1'b1, ss);
        wr(8'h74, 1'b0);
        chk_bit("irq", 1'b1, irq);
        wr(8'ha5, 1'b0);
        M.stop();
        chk_bit("stop", 1'b1, ps);
        pop(8'h74);
        pop(8'ha5);
        pulse(irqc);
        M.start();
        wr(8'h76, 1'b1);
        M.stop();
        chk_bit("irq", 1'b0, irq);
        chk_bit("rx_valid", 1'b0, rxv);
        M.glitch();
        chk_bit("start", 1'b1, ss);
        chk_bit("stop", 1'b0, ps);
        mask = 10'h004;
        M.start();
        wr(8'h7d, 1'b0);
        M.xfer(8'hff, q, 1'b1, ack);
        chk_byte("tx", 8'h96, q);
        chk_bit("ack_status", 1'b1, acks);
        M.stop();
        pop(8'h7d);
        txd = 8'hff;
        M.start();
        wr(8'h75, 1'b0);
        M.xfer(8'h00, q, 1'b1, ack);
        chk_bit("collision", 1'b1, col);
        pulse(colc);
        chk_bit("collision", 1'b0, col);
        M.stop();
        pop(8'h75);
        M.start();
        wr(8'h74, 1'b0);
        for (int i = 0; i < 15; i++)
            wr(8'(i), 1'b0);
        chk_bit("full", 1'b1, bff);
        wr(8'h5a, 1'b1);
        chk_bit("overflow", 1'b1, ovf);
        M.stop();
        pop(8'h74);
        for (int i = 0; i < 15; i++)
            pop(8'(i));
        chk_bit("rx_valid", 1'b0, rxv);
        pulse(ovc);
        chk_bit("overflow", 1'b0, ovf);
        for (int k = 0; k < 2; k++)
        begin
            mode = k ? MODE_7BIT : MODE_7BIT_SP;
            sie = 1'(k);
            pulse(irqc);
            M.start();
            chk_bit("irq", 1'b1, irq);
            M.stop();
        end
        mode = MODE_10BIT;
        addr = 10'h2c5;
        M.start();
        wr(8'hf4, 1'b0);
        wr(8'hc5, 1'b0);
        chk_bit("prior", 1'b1, pm);
        M.start();
        wr(8'hf5, 1'b0);
        M.xfer(8'hff, q, 1'b1, ack);
        M.stop();
        chk_bit("prior", 1'b0, pm);
        mode = MODE_7BIT;
        addr = 10'h03a;
        for (int h = 0; h < 2; h++)
        begin
            hts = 1'(h);
            M.start();
            M.xfer(8'h74, q, 1'b1, ack);
            #50;
            chk_bit("hold", 1'(1 - h), sda);
            M.stop();
        end
        ahe = 1'b1;
        for (int a = 0; a < 2; a++)
        begin
            ackd = 1'(a);
            M.start();
            wr(8'h74, 1'(a));
            chk_bit("ack_time", 1'b0, ackt);
            M.stop();
        end
        complete_run();
    end
endmodule
